// ==== rtl/nob_busy_timer.sv ====
`timescale 1ns/10ps
`include "nob_regs.svh"
module nob_busy_timer #(
  parameter int W = 20
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output logic              done_out
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         run;
  logic         next_run;

  always_comb begin
    next_cnt = cnt;
    next_run = run;
    done_out = run && (cnt == '0);
    if (load_in) begin
      next_cnt = count_in;
      next_run = 1'b1;
    end else if (done_out) begin
      next_run = 1'b0;
    end else if (run) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt <= '0;
      run <= 1'b0;
    end else if (ce_in) begin
      cnt <= next_cnt;
      run <= next_run;
    end
  end
endmodule

// ==== rtl/nob_pkg.sv ====
package nob_pkg;
  typedef enum logic [3:0] {
    NOB_OP_NONE    = 4'h0,
    NOB_OP_RD      = 4'h1,
    NOB_OP_SEQSTOP = 4'h2,
    NOB_OP_PROG    = 4'h3,
    NOB_OP_OTP     = 4'h4,
    NOB_OP_ERASE   = 4'h5,
    NOB_OP_WRSR    = 4'h6,
    NOB_OP_SLEEP   = 4'h7,
    NOB_OP_WAKE    = 4'h8,
    NOB_OP_RESET   = 4'h9,
    NOB_OP_STATUS  = 4'hA,
    NOB_OP_MARKRD  = 4'hB
  } nob_op_e;
  typedef enum logic [2:0] {
    NOB_ST_IDLE    = 3'b000,
    NOB_ST_BUSY    = 3'b001,
    NOB_ST_ENTER   = 3'b010,
    NOB_ST_SLEEP   = 3'b011,
    NOB_ST_WAKE    = 3'b100
  } nob_state_e;
  typedef logic [19:0] nob_cnt_t;
endpackage

// ==== rtl/nob_regs.svh ====
`ifndef NOB_REGS_SVH
`define NOB_REGS_SVH
// What this block does
// - Page load without error correction finishes within 25 us.
// - Page load with error correction finishes within 60 us.
// - Stopping a sequential read returns to ready within 7 us.
// - Program or lock finishes within 700 us (typ 250); erase within 10 ms.
// - Deep sleep entered within 3 us after select rises.
// - Release from deep sleep reaches standby within 1.5 ms.
// - Status register write completes within 50 ns.
// - Block zero is always valid.
// - Valid block count lies between 2008 and 2048.
// - Invalid blocks carry non-all-ones mark bytes in their first page.
// - Erase never removes factory invalid-block marks.
// - Device ships erased with invalid blocks marked; the marks last until rst_in clears them.
// - In deep sleep only release and reset commands are recognised.

// ***************************************
// Timing figures and derived cycle counts
// ***************************************
`define NOB_CLK_MHZ          50
`define NOB_T_RD1_US         25
`define NOB_T_RD2_US         60
`define NOB_T_RD3_US         7
`define NOB_T_PP_US          700
`define NOB_T_BE_MS          10
`define NOB_T_DP_US          3
`define NOB_T_RES_US         1500
`define NOB_T_W_NS           50
`define NOB_CLK_NS           20
`define NOB_CYC_RD1          (`NOB_T_RD1_US * `NOB_CLK_MHZ)
`define NOB_CYC_RD2          (`NOB_T_RD2_US * `NOB_CLK_MHZ)
`define NOB_CYC_RD3          (`NOB_T_RD3_US * `NOB_CLK_MHZ)
`define NOB_CYC_PP           (`NOB_T_PP_US * `NOB_CLK_MHZ)
`define NOB_CYC_BE           (`NOB_T_BE_MS * 1000 * `NOB_CLK_MHZ)
`define NOB_CYC_DP           (`NOB_T_DP_US * `NOB_CLK_MHZ)
`define NOB_CYC_RES          (`NOB_T_RES_US * `NOB_CLK_MHZ)
`define NOB_CYC_W            (`NOB_T_W_NS / `NOB_CLK_NS)

// ***************************************
// Array shape and marks
// ***************************************
`define NOB_BLOCKS           2048
`define NOB_MIN_VALID        2008
`define NOB_BLK_W            11
`define NOB_MARK_GOOD        8'hFF
`define NOB_MARK_BAD         8'h00
`define NOB_PARTIAL_LIMIT    4
`define NOB_TMR_W            20
`endif

// ==== rtl/nob_sequencer.sv ====
`timescale 1ns/10ps
`include "nob_regs.svh"
module nob_sequencer #(
  parameter int TMR_W     = `NOB_TMR_W,
  parameter int CYC_RD1   = `NOB_CYC_RD1,
  parameter int CYC_RD2   = `NOB_CYC_RD2,
  parameter int CYC_RD3   = `NOB_CYC_RD3,
  parameter int CYC_PP    = `NOB_CYC_PP,
  parameter int CYC_BE    = `NOB_CYC_BE,
  parameter int CYC_DP    = `NOB_CYC_DP,
  parameter int CYC_RES   = `NOB_CYC_RES,
  parameter int BLK_W     = `NOB_BLK_W,
  parameter int BLOCKS    = `NOB_BLOCKS
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic             cmd_valid_in,
  input  wire logic [3:0]       cmd_op_in,
  input  wire logic             ecc_en_in,
  input  wire logic [BLK_W-1:0] cmd_block_in,
  input  wire logic             fact_bad_load_in,
  input  wire logic [BLK_W-1:0] fact_bad_block_in,
  output logic                  cmd_accept_out,
  output logic                  busy_out,
  output logic                  sleep_out,
  output logic                  wel_out,
  output logic [7:0]            mark_data_out,
  output logic                  mark_valid_out,
  output logic [BLK_W:0]        valid_count_out
);
  // ***************************************
  // State
  // ***************************************
  nob_pkg::nob_state_e st;
  nob_pkg::nob_state_e next_st;
  logic [BLOCKS-1:0]   bad;
  logic [BLOCKS-1:0]   next_bad;
  logic [BLK_W:0]      nbad;
  logic [BLK_W:0]      next_nbad;
  logic [7:0]          mark;
  logic [7:0]          next_mark;
  logic                mvalid;
  logic                next_mvalid;
  logic                wr_lat;
  logic                next_wr_lat;
  logic                tmr_load;
  logic [TMR_W-1:0]    tmr_count;
  logic                tmr_done;
  nob_pkg::nob_op_e    op;

  assign op = nob_pkg::nob_op_e'(cmd_op_in);

  function automatic logic [TMR_W-1:0] op_cycles(input nob_pkg::nob_op_e o,
                                                 input logic ecc);
    case (o)
      nob_pkg::NOB_OP_RD:      op_cycles = ecc ? TMR_W'(CYC_RD2) : TMR_W'(CYC_RD1);
      nob_pkg::NOB_OP_SEQSTOP: op_cycles = TMR_W'(CYC_RD3);
      nob_pkg::NOB_OP_PROG,
      nob_pkg::NOB_OP_OTP:     op_cycles = TMR_W'(CYC_PP);
      nob_pkg::NOB_OP_ERASE:   op_cycles = TMR_W'(CYC_BE);
      default:                 op_cycles = '0;
    endcase
  endfunction

  // Timer counts N then flags; load with N-1 so done lands at N cycles
  nob_busy_timer #(
    .W (TMR_W)
  ) u_tmr (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .load_in     (tmr_load),
    .count_in    (tmr_count),
    .done_out    (tmr_done)
  );

  // ***************************************
  // Command sequencing
  // ***************************************
  always_comb begin
    next_st        = st;
    next_bad       = bad;
    next_nbad      = nbad;
    next_mark      = mark;
    next_mvalid    = 1'b0;
    next_wr_lat    = 1'b0;
    tmr_load       = 1'b0;
    tmr_count      = '0;
    cmd_accept_out = 1'b0;
    // Factory marking only while idle; block zero can never be marked
    if (fact_bad_load_in && (st == nob_pkg::NOB_ST_IDLE)
        && (fact_bad_block_in != '0)
        && !bad[fact_bad_block_in]
        && (nbad < BLK_W'(BLOCKS - `NOB_MIN_VALID))) begin
      next_bad[fact_bad_block_in] = 1'b1;
      next_nbad = nbad + 1'b1;
    end
    case (st)
      nob_pkg::NOB_ST_IDLE: begin
        if (cmd_valid_in) begin
          cmd_accept_out = 1'b1;
          case (op)
            nob_pkg::NOB_OP_RD,
            nob_pkg::NOB_OP_SEQSTOP,
            nob_pkg::NOB_OP_PROG,
            nob_pkg::NOB_OP_OTP,
            nob_pkg::NOB_OP_ERASE: begin
              tmr_load  = 1'b1;
              tmr_count = op_cycles(op, ecc_en_in) - 1'b1;
              next_st   = nob_pkg::NOB_ST_BUSY;
              // Erase leaves the bad map alone; only rst_in clears marks
            end
            nob_pkg::NOB_OP_WRSR: next_wr_lat = 1'b1;
            nob_pkg::NOB_OP_SLEEP: begin
              tmr_load  = 1'b1;
              tmr_count = TMR_W'(CYC_DP) - 1'b1;
              next_st   = nob_pkg::NOB_ST_ENTER;
            end
            nob_pkg::NOB_OP_MARKRD: begin
              // Bad blocks read non-FF at the mark bytes
              next_mark   = bad[cmd_block_in] ? `NOB_MARK_BAD : `NOB_MARK_GOOD;
              next_mvalid = 1'b1;
            end
            default: ;
          endcase
        end
      end
      nob_pkg::NOB_ST_BUSY,
      nob_pkg::NOB_ST_ENTER: begin
        if (tmr_done) begin
          next_st = (st == nob_pkg::NOB_ST_ENTER) ? nob_pkg::NOB_ST_SLEEP
                                                   : nob_pkg::NOB_ST_IDLE;
        end
      end
      nob_pkg::NOB_ST_SLEEP: begin
        // Everything else, status reads too, is dropped here
        if (cmd_valid_in) begin
          cmd_accept_out = 1'b1;
          if (op == nob_pkg::NOB_OP_WAKE) begin
            tmr_load  = 1'b1;
            tmr_count = TMR_W'(CYC_RES) - 1'b1;
            next_st   = nob_pkg::NOB_ST_WAKE;
          end else if (op == nob_pkg::NOB_OP_RESET) begin
            next_st = nob_pkg::NOB_ST_IDLE;
          end
        end
      end
      nob_pkg::NOB_ST_WAKE: begin
        if (tmr_done) begin
          next_st = nob_pkg::NOB_ST_IDLE;
        end
      end
      default: next_st = nob_pkg::NOB_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st     <= nob_pkg::NOB_ST_IDLE;
      bad    <= '0;
      nbad   <= '0;
      mark   <= 8'h00;
      mvalid <= 1'b0;
      wr_lat <= 1'b0;
    end else if (ce_in) begin
      st     <= next_st;
      bad    <= next_bad;
      nbad   <= next_nbad;
      mark   <= next_mark;
      mvalid <= next_mvalid;
      wr_lat <= next_wr_lat;
    end
  end

  // ***************************************
  // Outputs
  // ***************************************
  // Busy covers the whole timed window, sleep entry and wake included
  assign busy_out        = (st == nob_pkg::NOB_ST_BUSY) || (st == nob_pkg::NOB_ST_ENTER)
                           || (st == nob_pkg::NOB_ST_WAKE);
  assign sleep_out       = (st == nob_pkg::NOB_ST_SLEEP);
  assign wel_out         = wr_lat;
  assign mark_data_out   = mark;
  assign mark_valid_out  = mvalid;
  assign valid_count_out = (BLK_W+1)'(BLOCKS) - nbad;
endmodule

// ==== sim/nob_host.sv ====
`timescale 1ns/10ps
module nob_host #(
  // Longest reset recovery, 500 us at 50 MHz
  parameter int RST_WAIT = 25000
) (
  input  wire logic  core_clk_in,
  input  wire logic  busy_in,
  output logic       cmd_valid_out,
  output logic [3:0] cmd_op_out,
  output logic       ecc_en_out
);
  initial begin
    cmd_valid_out = 1'h0;
    cmd_op_out = 4'h0;
    ecc_en_out = 1'h0;
  end
  // *****
  // One command, then poll busy
  // *****
  task automatic pulse(input logic [3:0] op, input logic ecc);
    @(negedge core_clk_in);
    cmd_op_out = op;
    ecc_en_out = ecc;
    cmd_valid_out = 1'h1;
    @(negedge core_clk_in);
    cmd_valid_out = 1'h0;
    cmd_op_out = ~op;
  endtask
  task automatic wait_idle(input logic [3:0] op, output int busy_cyc);
    busy_cyc = 0;
    // Polling, not worst-case waits
    while (busy_in === 1'h1 && busy_cyc < 100000) begin
      busy_cyc++;
      @(negedge core_clk_in);
    end
    // A reset may have cut any operation short, so wait the longest case
    if (op == 4'h9) repeat (RST_WAIT) @(negedge core_clk_in);
    // Deselect gap of three 20 ns cycles
    repeat (3) @(negedge core_clk_in);
  endtask
  task automatic issue(input logic [3:0] op, input logic ecc, output int busy_cyc);
    pulse(op, ecc);
    wait_idle(op, busy_cyc);
  endtask
endmodule

// ==== sim/nob_seq_asserts.sv ====
`timescale 1ns/10ps
module nob_seq_asserts #(
  parameter int CYC_RD1 = 6,
  parameter int CYC_RD2 = 9,
  parameter int CYC_RD3 = 4,
  parameter int CYC_PP  = 12,
  parameter int CYC_BE  = 15,
  parameter int CYC_DP  = 5,
  parameter int CYC_RES = 8
) (
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  input wire logic       ce_in,
  input wire logic       cmd_valid_in,
  input wire logic [3:0] cmd_op_in,
  input wire logic       ecc_en_in,
  input wire logic       cmd_accept_out,
  input wire logic       busy_out,
  input wire logic       sleep_out,
  input wire logic       wel_out
);
  // *****
  // Busy length tracking
  // *****
  logic [3:0] op_q;
  logic       ecc_q;
  int         run;
  wire        acc  = cmd_valid_in & ce_in & cmd_accept_out;
  wire        take = acc & ~busy_out & ~sleep_out;
  // Count only enabled cycles, since ce low freezes the timer
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      run <= 0;
      op_q <= 4'h0;
      ecc_q <= 1'h0;
    end else if (ce_in) begin
      run <= busy_out ? run + 1 : 0;
      op_q <= acc ? cmd_op_in : op_q;
      ecc_q <= acc ? ecc_en_in : ecc_q;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // *****
  // Checks
  // *****
  // Busy is sampled high on exactly N edges, so run reaches N at the fall
  load_plain_a: assert property ($fell(busy_out) && op_q == 4'h1 && !ecc_q |->
    run == CYC_RD1) else $error("plain load length wrong");
  load_ecc_a: assert property ($fell(busy_out) && op_q == 4'h1 && ecc_q |->
    run == CYC_RD2) else $error("ecc load length wrong");
  seq_stop_a: assert property ($fell(busy_out) && op_q == 4'h2 |->
    run == CYC_RD3) else $error("sequential stop length wrong");
  prog_erase_a: assert property ($fell(busy_out) && op_q inside {4'h3, 4'h4, 4'h5} |->
    run == (op_q == 4'h5 ? CYC_BE : CYC_PP)) else $error("program or erase length wrong");
  sleep_entry_a: assert property ($fell(busy_out) && op_q == 4'h7 |->
    run == CYC_DP && sleep_out) else $error("sleep entry wrong");
  wake_time_a: assert property ($fell(busy_out) && op_q == 4'h8 |->
    run == CYC_RES && !sleep_out) else $error("wake length wrong");
  status_write_a: assert property (take && cmd_op_in == 4'h6 |=> wel_out && !busy_out)
    else $error("status write not done");
  sleep_ignore_a: assert property (sleep_out && acc && !(cmd_op_in inside {4'h8, 4'h9})
    |=> sleep_out && !busy_out) else $error("command acted in sleep");
  busy_shown_a: assert property (take &&
    cmd_op_in inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7} |=> busy_out)
    else $error("busy not shown");
  busy_refuse_a: assert property (busy_out && cmd_valid_in |-> !cmd_accept_out)
    else $error("command taken while busy");
endmodule
bind nob_sequencer nob_seq_asserts #(
  .CYC_RD1(CYC_RD1), .CYC_RD2(CYC_RD2), .CYC_RD3(CYC_RD3), .CYC_PP(CYC_PP), .CYC_BE(CYC_BE),
  .CYC_DP(CYC_DP), .CYC_RES(CYC_RES)
) u_chk (
  .core_clk_in, .rst_in, .ce_in, .cmd_valid_in, .cmd_op_in, .ecc_en_in,
  .cmd_accept_out, .busy_out, .sleep_out, .wel_out
);

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  localparam int RD1 = 6;
  localparam int RD2 = 9;
  localparam int RD3 = 4;
  localparam int PP  = 12;
  localparam int BE  = 15;
  localparam int DP  = 5;
  localparam int RES = 8;
  logic        core_clk_in = 1'h0;
  logic        rst_in = 1'h1;
  logic        ce_in = 1'h1;
  logic [10:0] cmd_block_in = 11'h000;
  logic        fact_bad_load_in = 1'h0;
  logic [10:0] fact_bad_block_in = 11'h000;
  logic        cmd_valid_in, ecc_en_in, cmd_accept_out, busy_out, sleep_out;
  logic        wel_out, mark_valid_out, last_acc;
  logic [3:0]  cmd_op_in;
  logic [7:0]  mark_data_out, last_mark;
  logic [11:0] valid_count_out;
  int          n_errors = 0, samples_checked = 0, n_wel = 0, cyc;
  always #10 core_clk_in = ~core_clk_in;
  nob_sequencer #(
    .CYC_RD1(RD1), .CYC_RD2(RD2), .CYC_RD3(RD3), .CYC_PP(PP), .CYC_BE(BE),
    .CYC_DP(DP), .CYC_RES(RES)
  ) i_nob_sequencer (
    .core_clk_in, .rst_in, .ce_in, .cmd_valid_in, .cmd_op_in, .ecc_en_in,
    .cmd_block_in, .fact_bad_load_in, .fact_bad_block_in, .cmd_accept_out,
    .busy_out, .sleep_out, .wel_out, .mark_data_out, .mark_valid_out, .valid_count_out
  );
  nob_host i_nob_host (
    .core_clk_in, .busy_in(busy_out), .cmd_valid_out(cmd_valid_in),
    .cmd_op_out(cmd_op_in), .ecc_en_out(ecc_en_in)
  );
  always @(posedge core_clk_in) begin
    if (wel_out === 1'h1) n_wel <= n_wel + 1;
    if (mark_valid_out === 1'h1) last_mark <= mark_data_out;
    else if (cmd_valid_in === 1'h1) last_mark <= 8'h5A;
    if (cmd_valid_in === 1'h1 && ce_in === 1'h1) last_acc <= cmd_accept_out;
  end
  // *****
  // Shared tasks
  // *****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic mark_bad(input logic [10:0] blk);
    @(negedge core_clk_in);
    fact_bad_block_in = blk;
    fact_bad_load_in = 1'h1;
    @(negedge core_clk_in);
    fact_bad_load_in = 1'h0;
  endtask
  task automatic read_mark(input logic [10:0] blk, input logic [7:0] exp);
    cmd_block_in = blk;
    i_nob_host.issue(4'hB, 1'h0, cyc);
    chk(last_mark, exp);
  endtask
  // *****
  // Scenarios
  // *****
  task automatic t_timing;
    logic [3:0] ops [6] = '{4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
    int         exp [6] = '{RD1, RD2, RD3, PP, PP, BE};
    for (int i = 0; i < 6; i++) begin
      i_nob_host.issue(ops[i], i == 1, cyc);
      chk(cyc, exp[i]);
    end
    $display("timing test done");
  endtask
  // Erase pulsed two cycles into a program must be refused
  task automatic t_refuse;
    i_nob_host.pulse(4'h3, 1'h0);
    chk(last_acc, 1'h1);
    i_nob_host.pulse(4'h5, 1'h0);
    chk(last_acc, 1'h0);
    i_nob_host.wait_idle(4'h3, cyc);
    chk(cyc, PP - 2);
    $display("refuse test done");
  endtask
  task automatic t_wsr;
    int w0;
    w0 = n_wel;
    i_nob_host.issue(4'h6, 1'h0, cyc);
    i_nob_host.issue(4'h6, 1'h0, cyc);
    chk(cyc, 0);
    chk(n_wel - w0, 2);
    ce_in = 1'h0;
    i_nob_host.issue(4'h3, 1'h0, cyc);
    ce_in = 1'h1;
    chk(cyc, 0);
    $display("status write test done");
  endtask
  task automatic t_marks;
    mark_bad(11'h005);
    mark_bad(11'h005);
    mark_bad(11'h000);
    chk(valid_count_out, 12'h7FF);
    read_mark(11'h005, 8'h00);
    read_mark(11'h000, 8'hFF);
    i_nob_host.issue(4'h5, 1'h0, cyc);
    read_mark(11'h005, 8'h00);
    for (int b = 16; b < 60; b++) mark_bad(b[10:0]);
    chk(valid_count_out, 12'h7D8);
    read_mark(11'h03B, 8'hFF);
    read_mark(11'h006, 8'hFF);
    $display("mark test done");
  endtask
  task automatic t_sleep;
    i_nob_host.issue(4'h7, 1'h0, cyc);
    chk({cyc[30:0], sleep_out}, {DP[30:0], 1'h1});
    i_nob_host.issue(4'hA, 1'h0, cyc);
    i_nob_host.issue(4'h3, 1'h0, cyc);
    chk({cyc[30:0], sleep_out}, 1);
    i_nob_host.issue(4'h8, 1'h0, cyc);
    chk({cyc[30:0], sleep_out}, {RES[30:0], 1'h0});
    i_nob_host.issue(4'h7, 1'h0, cyc);
    i_nob_host.issue(4'h9, 1'h0, cyc);
    chk({busy_out, sleep_out}, 0);
    $display("sleep test done");
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_in = 1'h0;
    chk({busy_out, sleep_out, valid_count_out}, 14'h0800);
    t_timing;
    t_refuse;
    t_wsr;
    t_marks;
    t_sleep;
    tally_and_finish;
  end
endmodule
